/* File: bax_map.vh */
`ifndef BAX_MAP_VH
`define BAX_MAP_VH

// ****************************************************************
// Register byte offsets on the APB port.
// ****************************************************************
`define BAX_OFF_CMD 12'h000
`define BAX_OFF_ACC 12'h004
`define BAX_OFF_STATUS 12'h008
`define BAX_OFF_FADDR 12'h00C
`define BAX_OFF_FDATA 12'h010
`define BAX_OFF_RESULT 12'h014
`define BAX_OFF_OPCNT 12'h018

// ****************************************************************
// Command register fields.
// ****************************************************************
`define BAX_CMD_OP_LO 0
`define BAX_CMD_OP_HI 1
`define BAX_CMD_DEST 2
`define BAX_CMD_FADDR_LO 8
`define BAX_CMD_FADDR_HI 14
`define BAX_CMD_LIT_LO 16
`define BAX_CMD_LIT_HI 23

// ****************************************************************
// Operation codes.
// ****************************************************************
`define BAX_OP_SUB 2'h0
`define BAX_OP_XORF 2'h1
`define BAX_OP_SWAP 2'h2
`define BAX_OP_XORL 2'h3

// ****************************************************************
// Destination select values.
// ****************************************************************
`define BAX_DEST_ACC 1'h0
`define BAX_DEST_FILE 1'h1

// ****************************************************************
// Status register fields.
// ****************************************************************
`define BAX_ST_CARRY 0
`define BAX_ST_HALF 1
`define BAX_ST_ZERO 2
`define BAX_ST_BUSY 3

// ****************************************************************
// Reset values.
// ****************************************************************
`define BAX_RST_ACC 8'h00
`define BAX_RST_FLAG 1'h0
`define BAX_RST_FADDR 7'h00
`define BAX_RST_CNT 16'h0000

`endif

/* File: bax_file_mem.v */
`timescale 1ns/100ps

// ****************************************************************
// Single port file register array with registered read data.
// ****************************************************************
module bax_file_mem #(
  parameter AW = 7,
  parameter DW = 8
) (
  // Clock.
  input wire clk_i,
  // Access port.
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  output reg [DW-1:0] rdata_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule

/* File: bax_alu.v */
`timescale 1ns/100ps
`include "bax_map.vh"

// ****************************************************************
// Combinational result and flag logic for the four operations.
// ****************************************************************
module bax_alu (
  // Operation and operands.
  input wire [1:0] op_i,
  input wire [7:0] acc_i,
  input wire [7:0] freg_i,
  input wire [7:0] lit_i,
  // Result and flags.
  output reg [7:0] result_o,
  output reg carry_o,
  output reg half_o,
  output wire zero_o,
  output reg upd_carry_o,
  output reg upd_zero_o
);

  wire [8:0] diff;
  wire [4:0] low_diff;

  // Adding the inverted accumulator plus one gives borrow-free carry out.
  assign diff = {1'b0, freg_i} + {1'b0, ~acc_i} + 9'h001;
  assign low_diff = {1'b0, freg_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
  assign zero_o = (result_o == 8'h00);

  always @* begin
    result_o = freg_i;
    carry_o = 1'b0;
    half_o = 1'b0;
    upd_carry_o = 1'b0;
    upd_zero_o = 1'b0;
    case (op_i)
      `BAX_OP_SUB: begin
        result_o = diff[7:0];
        carry_o = diff[8];
        half_o = low_diff[4];
        upd_carry_o = 1'b1;
        upd_zero_o = 1'b1;
      end
      `BAX_OP_XORF: begin
        result_o = acc_i ^ freg_i;
        upd_zero_o = 1'b1;
      end
      `BAX_OP_SWAP: begin
        result_o = {freg_i[3:0], freg_i[7:4]};
      end
      `BAX_OP_XORL: begin
        result_o = acc_i ^ lit_i;
        upd_zero_o = 1'b1;
      end
      default: begin
        result_o = freg_i;
      end
    endcase
  end

endmodule

/* File: bax_top.v */
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
`include "bax_map.vh"


module bax_top #(
  parameter FILE_AW = 7
) (
  // Clock and reset.
  input wire clk_sys_i,
  input wire rstn_i,
  // APB slave port.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // Core state.
  output reg [7:0] acc_o,
  output reg carry_o,
  output reg half_carry_flag_o,
  output reg zero_o,
  output reg busy_o
);

  // ****************************************************************
  // State and storage.
  // ****************************************************************
  localparam S_IDLE = 2'b00;
  localparam S_OPRD = 2'b01;
  localparam S_FRD = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [1:0] cmd_op;
  reg cmd_dest;
  reg [FILE_AW-1:0] cmd_faddr;
  reg [7:0] cmd_lit;
  reg [FILE_AW-1:0] faddr;
  reg [7:0] last_result;
  reg [15:0] op_count;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire access;
  wire wr_any;
  wire wr_low;
  wire sel_cmd;
  wire sel_acc;
  wire sel_status;
  wire sel_faddr;
  wire sel_fdata;
  wire sel_result;
  wire sel_opcnt;
  wire mapped;
  wire [1:0] new_op;
  wire new_dest;
  wire [FILE_AW-1:0] new_faddr;
  wire [7:0] new_lit;

  assign access = psel_i & penable_i & ~pready_o;
  assign wr_any = pwrite_i & (pstrb_i != 4'h0);
  assign wr_low = pwrite_i & pstrb_i[0];
  assign sel_cmd = (paddr_i == `BAX_OFF_CMD);
  assign sel_acc = (paddr_i == `BAX_OFF_ACC);
  assign sel_status = (paddr_i == `BAX_OFF_STATUS);
  assign sel_faddr = (paddr_i == `BAX_OFF_FADDR);
  assign sel_fdata = (paddr_i == `BAX_OFF_FDATA);
  assign sel_result = (paddr_i == `BAX_OFF_RESULT);
  assign sel_opcnt = (paddr_i == `BAX_OFF_OPCNT);
  assign mapped = sel_cmd | sel_acc | sel_status | sel_faddr |
                  sel_fdata | sel_result | sel_opcnt;

  assign new_op = pwdata_i[`BAX_CMD_OP_HI:`BAX_CMD_OP_LO];
  assign new_dest = pwdata_i[`BAX_CMD_DEST];
  assign new_faddr = pwdata_i[`BAX_CMD_FADDR_HI:`BAX_CMD_FADDR_LO];
  assign new_lit = pwdata_i[`BAX_CMD_LIT_HI:`BAX_CMD_LIT_LO];

  wire start_cmd;
  wire start_imm;
  wire start_file;

  assign start_cmd = (state == S_IDLE) & access & sel_cmd & wr_any;
  assign start_imm = start_cmd & (new_op == `BAX_OP_XORL);
  assign start_file = start_cmd & (new_op != `BAX_OP_XORL);

  // ****************************************************************
  // Datapath.
  // ****************************************************************
  wire [7:0] mem_rdata;
  wire [7:0] alu_result;
  wire alu_carry;
  wire alu_half;
  wire alu_zero;
  wire alu_upd_carry;
  wire alu_upd_zero;
  wire [1:0] alu_op;
  wire file_dest;

  assign alu_op = (state == S_OPRD) ? cmd_op : new_op;
  assign file_dest = (cmd_dest == `BAX_DEST_FILE);

  bax_alu u_alu (
    .op_i(alu_op),
    .acc_i(acc_o),
    .freg_i(mem_rdata),
    .lit_i(new_lit),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .half_o(alu_half),
    .zero_o(alu_zero),
    .upd_carry_o(alu_upd_carry),
    .upd_zero_o(alu_upd_zero)
  );

  // ****************************************************************
  // File register port arbitration.
  // ****************************************************************
  reg mem_we;
  reg [FILE_AW-1:0] mem_addr;
  reg [7:0] mem_wdata;

  always @* begin
    mem_we = 1'b0;
    mem_addr = faddr;
    mem_wdata = pwdata_i[7:0];
    case (state)
      S_IDLE: begin
        if (start_file) begin
          mem_addr = new_faddr;
        end else if (access & sel_fdata & wr_low) begin
          mem_we = 1'b1;
        end
      end
      S_OPRD: begin
        mem_addr = cmd_faddr;
        mem_wdata = alu_result;
        mem_we = file_dest;
      end
      default: begin
        mem_addr = faddr;
      end
    endcase
  end

  bax_file_mem #(
    .AW(FILE_AW),
    .DW(8)
  ) u_mem (
    .clk_i(clk_sys_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start_file) begin
          next_state = S_OPRD;
        end else if (access & sel_fdata & ~pwrite_i) begin
          next_state = S_FRD;
        end
      end
      S_OPRD: begin
        next_state = S_IDLE;
      end
      S_FRD: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Read data mux for single-cycle registers.
  // ****************************************************************
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (sel_cmd) begin
      rd_mux[`BAX_CMD_OP_HI:`BAX_CMD_OP_LO] = cmd_op;
      rd_mux[`BAX_CMD_DEST] = cmd_dest;
      rd_mux[`BAX_CMD_FADDR_HI:`BAX_CMD_FADDR_LO] = cmd_faddr;
      rd_mux[`BAX_CMD_LIT_HI:`BAX_CMD_LIT_LO] = cmd_lit;
    end else if (sel_acc) begin
      rd_mux[7:0] = acc_o;
    end else if (sel_status) begin
      rd_mux[`BAX_ST_CARRY] = carry_o;
      rd_mux[`BAX_ST_HALF] = half_carry_flag_o;
      rd_mux[`BAX_ST_ZERO] = zero_o;
      rd_mux[`BAX_ST_BUSY] = busy_o;
    end else if (sel_faddr) begin
      rd_mux[FILE_AW-1:0] = faddr;
    end else if (sel_result) begin
      rd_mux[7:0] = last_result;
    end else if (sel_opcnt) begin
      rd_mux[15:0] = op_count;
    end
  end

  // ****************************************************************
  // Registers and bus answers.
  // ****************************************************************
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state <= S_IDLE;
      cmd_op <= `BAX_OP_SUB;
      cmd_dest <= `BAX_DEST_ACC;
      cmd_faddr <= `BAX_RST_FADDR;
      cmd_lit <= `BAX_RST_ACC;
      faddr <= `BAX_RST_FADDR;
      last_result <= `BAX_RST_ACC;
      op_count <= `BAX_RST_CNT;
      acc_o <= `BAX_RST_ACC;
      carry_o <= `BAX_RST_FLAG;
      half_carry_flag_o <= `BAX_RST_FLAG;
      zero_o <= `BAX_RST_FLAG;
      busy_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      state <= next_state;
      busy_o <= (next_state == S_OPRD);
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (access & ~sel_fdata & ~start_file) begin
            // Everything not touching the array answers at once.
            pready_o <= 1'b1;
            pslverr_o <= ~mapped;
            prdata_o <= pwrite_i ? 32'h00000000 : rd_mux;
          end else if (access & sel_fdata & pwrite_i) begin
            pready_o <= 1'b1;
            prdata_o <= 32'h00000000;
          end
          if (start_cmd) begin
            cmd_op <= new_op;
            cmd_dest <= new_dest;
            cmd_faddr <= new_faddr;
            cmd_lit <= new_lit;
          end
          if (start_imm) begin
            acc_o <= alu_result;
            zero_o <= alu_zero;
            last_result <= alu_result;
            op_count <= op_count + 16'h0001;
          end
          if (access & wr_low & sel_acc) begin
            acc_o <= pwdata_i[7:0];
          end
          if (access & wr_low & sel_status) begin
            carry_o <= pwdata_i[`BAX_ST_CARRY];
            half_carry_flag_o <= pwdata_i[`BAX_ST_HALF];
            zero_o <= pwdata_i[`BAX_ST_ZERO];
          end
          if (access & wr_low & sel_faddr) begin
            faddr <= pwdata_i[FILE_AW-1:0];
          end
          if (access & wr_any & sel_opcnt) begin
            op_count <= `BAX_RST_CNT;
          end
        end
        S_OPRD: begin
          if (!file_dest) begin
            acc_o <= alu_result;
          end
          if (alu_upd_carry) begin
            carry_o <= alu_carry;
            half_carry_flag_o <= alu_half;
          end
          if (alu_upd_zero) begin
            zero_o <= alu_zero;
          end
          last_result <= alu_result;
          op_count <= op_count + 16'h0001;
          pready_o <= 1'b1;
          prdata_o <= 32'h00000000;
        end
        S_FRD: begin
          pready_o <= 1'b1;
          prdata_o <= {24'h000000, mem_rdata};
        end
        default: begin
          pready_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* File: bax_top_monitor.sv */
`timescale 1ns/100ps
`include "bax_map.vh"

// ****************************************************************
// Port checker for the datapath top.
// ****************************************************************
module bax_mon (
  // Clock and reset.
  input wire clk_sys_i,
  input wire rstn_i,
  // APB request and ready answer.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  input wire pready_o,
  // Core state.
  input wire [7:0] acc_o,
  input wire carry_o,
  input wire half_carry_flag_o,
  input wire zero_o,
  input wire busy_o
);
  // A file operation keeps the access phase open for two edges; busy marks
  // the second one, so only the first edge counts as the command being taken.
  wire take = psel_i && penable_i && pwrite_i && !pready_o &&
    !busy_o && paddr_i == `BAX_OFF_CMD && pstrb_i != 4'h0;
  wire [1:0] op = pwdata_i[1:0];
  wire dst = pwdata_i[2];
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  property p_sub;
    take && op == `BAX_OP_SUB && !dst |-> ##2 zero_o == (acc_o == 8'h00)
      && carry_o == ((9'h000 + acc_o + $past(acc_o, 2)) < 9'h100)
      && half_carry_flag_o == ((9'h000 + (acc_o & 8'h0F)
      + ($past(acc_o, 2) & 8'h0F)) < 9'h010);
  endproperty
  a_sub: assert property (p_sub)
    else $error("sub flags wrong");
  property p_xorz;
    take && op == `BAX_OP_XORF && !dst |-> ##2 zero_o == (acc_o == 8'h00);
  endproperty
  a_xorz: assert property (p_xorz)
    else $error("xor zero wrong");
  property p_xorc;
    take && op == `BAX_OP_XORF |-> ##2 carry_o == $past(carry_o, 2) &&
      half_carry_flag_o == $past(half_carry_flag_o, 2);
  endproperty
  a_xorc: assert property (p_xorc)
    else $error("xor moved carry");
  property p_dest;
    take && op != `BAX_OP_XORL && dst |-> ##1 $stable(acc_o) [*2];
  endproperty
  a_dest: assert property (p_dest)
    else $error("acc changed");
  property p_swap;
    take && op == `BAX_OP_SWAP |->
      ##1 $stable({carry_o, half_carry_flag_o, zero_o}) [*2];
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap moved flags");
  property p_xorl;
    take && op == `BAX_OP_XORL |=> zero_o == (acc_o == 8'h00) &&
      acc_o == ($past(acc_o) ^ $past(pwdata_i[23:16]));
  endproperty
  a_xorl: assert property (p_xorl)
    else $error("literal xor wrong");
  property p_busy;
    take && op != `BAX_OP_XORL |=> busy_o ##1 (pready_o && !busy_o);
  endproperty
  a_busy: assert property (p_busy)
    else $error("file op timing");
endmodule

bind bax_top bax_mon u_mon (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .pready_o(pready_o), .acc_o(acc_o), .carry_o(carry_o),
  .half_carry_flag_o(half_carry_flag_o), .zero_o(zero_o), .busy_o(busy_o));

/* File: bax_apb_bfm.sv */
`timescale 1ns/100ps

// ****************************************************************
// APB master standing in for the core sequencer.
// ****************************************************************
module bax_apb_bfm (
  // Clock.
  input wire clk_i,
  // Request.
  output reg psel_o = 1'b0,
  output reg penable_o = 1'b0,
  output reg pwrite_o = 1'b0,
  output reg [11:0] paddr_o = 12'h000,
  output reg [31:0] pwdata_o = 32'h0,
  output reg [3:0] pstrb_o = 4'h0,
  // Answer.
  input wire [31:0] prdata_i,
  input wire pready_i,
  input wire pslverr_i
);
  task xfer(input w, input [11:0] a, input [31:0] d, input [3:0] s,
    output [31:0] q, output er);
    begin
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      pstrb_o <= s;
      @(posedge clk_i);
      penable_o <= 1'b1;
      @(posedge clk_i);
      while (pready_i !== 1'b1) @(posedge clk_i);
      q = prdata_i;
      er = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
    end
  endtask
endmodule

/* File: byte_alu_sub_xor_swap_tb_top.sv */
`timescale 1ns/100ps

// ****************************************************************
// Self-checking bench for the datapath top.
// ****************************************************************
module byte_alu_sub_xor_swap_tb_top;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, carry, half, zero, busy;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] pstrb;
  wire [7:0] acc;
  reg [7:0] last_r = 8'h00;
  integer num_errors = 0;
  integer n_compared = 0;
  integer ops = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  bax_top dut (.clk_sys_i(clk), .rstn_i(rstn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .acc_o(acc), .carry_o(carry),
    .half_carry_flag_o(half), .zero_o(zero), .busy_o(busy));
  bax_apb_bfm u_bfm (.clk_i(clk), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .pstrb_o(pstrb), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task wr(input [11:0] a, input [31:0] d, input [3:0] s);
    reg [31:0] q;
    reg er;
    begin
      u_bfm.xfer(1'b1, a, d, s, q, er);
      chk({31'h0, er}, 32'h0);
    end
  endtask

  task rd(input [11:0] a, input [31:0] e, input ee);
    reg [31:0] q;
    reg er;
    begin
      u_bfm.xfer(1'b0, a, 32'h0, 4'h0, q, er);
      chk(q, e);
      chk({31'h0, er}, {31'h0, ee});
    end
  endtask

  // Loads operands, issues one command and checks every destination.
  task do_op(input [1:0] op, input dst, input [6:0] fa, input [7:0] f,
    input [7:0] w, input [7:0] k);
    reg [7:0] r, ea, ef;
    reg [2:0] st;
    begin
      wr(12'h00C, {25'h0, fa}, 4'h1);
      wr(12'h010, {24'h0, f}, 4'h1);
      wr(12'h004, {24'h0, w}, 4'h1);
      // Zero starts set so that an operation which wrongly clears it shows.
      wr(12'h008, 32'h7, 4'h1);
      wr(12'h000, {8'h0, k, 1'b0, fa, 5'h0, dst, op}, 4'hF);
      st = 3'b111;
      ea = w;
      ef = f;
      case (op)
        2'h0: begin
          r = f - w;
          st = {r == 8'h00, w[3:0] <= f[3:0], w <= f};
        end
        2'h1: begin
          r = w ^ f;
          st[2] = (r == 8'h00);
        end
        2'h2: r = {f[3:0], f[7:4]};
        default: begin
          r = w ^ k;
          st[2] = (r == 8'h00);
        end
      endcase
      if (dst && op != 2'h3) ef = r;
      else ea = r;
      ops = ops + 1;
      last_r = r;
      chk({24'h0, acc}, {24'h0, ea});
      chk({29'h0, zero, half, carry}, {29'h0, st});
      rd(12'h008, {29'h0, st}, 1'b0);
      rd(12'h010, {24'h0, ef}, 1'b0);
      rd(12'h014, {24'h0, r}, 1'b0);
    end
  endtask

  task t_reset;
    begin
      chk({24'h0, acc}, 32'h0);
      rd(12'h008, 32'h0, 1'b0);
      rd(12'h00C, 32'h0, 1'b0);
      rd(12'h018, 32'h0, 1'b0);
      $display("t_reset done");
    end
  endtask

  task t_ops;
    begin
      do_op(2'h0, 1'b0, 7'h7F, 8'h10, 8'h01, 8'h00);
      do_op(2'h0, 1'b1, 7'h00, 8'h05, 8'h05, 8'h00);
      do_op(2'h0, 1'b0, 7'h40, 8'h01, 8'h02, 8'h00);
      do_op(2'h1, 1'b0, 7'h7F, 8'hA5, 8'h5A, 8'h00);
      do_op(2'h1, 1'b1, 7'h01, 8'h3C, 8'h3C, 8'h00);
      do_op(2'h2, 1'b0, 7'h12, 8'h12, 8'h77, 8'h00);
      do_op(2'h2, 1'b1, 7'h7F, 8'hF0, 8'h00, 8'h00);
      do_op(2'h3, 1'b0, 7'h00, 8'h00, 8'h55, 8'h55);
      do_op(2'h3, 1'b1, 7'h33, 8'h99, 8'h0F, 8'hF0);
      $display("t_ops done");
    end
  endtask

  task t_refuse;
    begin
      rd(12'h100, 32'h0, 1'b1);
      wr(12'h004, 32'h0000_00AA, 4'h1);
      wr(12'h004, 32'h0000_0055, 4'h0);
      chk({24'h0, acc}, 32'h0000_00AA);
      wr(12'h014, 32'h0000_00FF, 4'hF);
      rd(12'h014, {24'h0, last_r}, 1'b0);
      rd(12'h018, ops, 1'b0);
      wr(12'h018, 32'h0, 4'hF);
      rd(12'h018, 32'h0, 1'b0);
      $display("t_refuse done");
    end
  endtask

  task wrap_up;
    begin
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_ops;
    t_refuse;
    wrap_up;
  end

  initial begin
    // The tests need well under a thousand cycles; this leaves ample margin.
    repeat (20000) @(posedge clk);
    num_errors = num_errors + 1;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule
